// ===== rtl/mwu_pkg.sv
// Shared constants and types for the multi-input wake-up block
package mwu_pkg;

  // Register map, byte-wide registers on a 4-bit address
  localparam logic [3:0] MWU_OFF_WAKE_EN   = 4'h0;
  localparam logic [3:0] MWU_OFF_WAKE_EDGE = 4'h1;
  localparam logic [3:0] MWU_OFF_WAKE_PND  = 4'h2;
  localparam logic [3:0] MWU_OFF_CTRL      = 4'h3;
  localparam logic [3:0] MWU_OFF_STATUS    = 4'h4;
  localparam logic [3:0] MWU_OFF_TMR_LO    = 4'h5;
  localparam logic [3:0] MWU_OFF_TMR_HI    = 4'h6;

  // Control register field positions
  localparam int MWU_CTRL_GIE      = 0;
  localparam int MWU_CTRL_PIN_GROUP_IRQ_ENABLE     = 1;
  localparam int MWU_CTRL_IDLE_TIMER_IRQ_ENABLE     = 2;
  localparam int MWU_CTRL_IDLE_TIMER_PENDING    = 3;
  localparam int MWU_CTRL_IDLE_REQ = 6;
  localparam int MWU_CTRL_HALT_REQ = 7;

  // Values after reset
  localparam logic [7:0]  MWU_RST_BYTE  = 8'h00;
  localparam logic [12:0] MWU_RST_TIMER = 13'h0000;

  // Geometry
  localparam int MWU_PINS     = 8;
  localparam int MWU_IRQ_PINS = 7;
  localparam int MWU_TMR_W    = 13;

  // Timing: system clock and instruction cycle
  localparam int MWU_CLK_NS = 25;
  localparam int MWU_TC_NS  = 1000;
  localparam int MWU_TC_CYC = (MWU_TC_NS + MWU_CLK_NS - 1) / MWU_CLK_NS;

  // Idle wake period 4.096 ms, counted in instruction cycles
  localparam int MWU_IDLE_WAKE_US    = 4096;
  localparam int MWU_IDLE_WAKE_TICKS = MWU_IDLE_WAKE_US * 1000 / MWU_TC_NS;
  localparam int MWU_TOGGLE_BIT      = $clog2(MWU_IDLE_WAKE_TICKS);

  // Oscillator settling load of the settle counter
  localparam logic [8:0] MWU_SETTLE_LOAD = 9'h100;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mwu_bus_s;

  // Power states
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_HALT,
    PWR_IDLE,
    PWR_SETTLE
  } mwu_pwr_e;

endpackage : mwu_pkg

// ===== rtl/mwu_sync_edge.sv
// Two-stage synchroniser with edge detection for a group of pins
`timescale 1ns/1ps
module mwu_sync_edge
  import mwu_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges seen on the stable stage only, one pulse per transition
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : mwu_sync_edge

// ===== rtl/mwu_wakeup.sv
// Multi-input wake-up, idle timer and power-mode control
`timescale 1ns/1ps
module mwu_wakeup
  import mwu_pkg::*;
#(
  parameter int TC_CYCLES = MWU_TC_CYC
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire mwu_bus_s            bus,
  output logic      [7:0]          rdata,
  input  wire logic [MWU_PINS-1:0] wake_pin_in,
  input  wire logic                can_rx_comp,
  input  wire logic                halt_feature_enable,
  output logic                     core_clock_enable,
  output logic                     osc_enable,
  output mwu_pwr_e                 power_state,
  output logic                     irq_pin_group,
  output logic                     irq_idle_timer,
  output logic                     resume_pulse
);

  // Address match shared by write and read decoding
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  logic [MWU_PINS-1:0]  wake_enable_mask_r;
  logic [MWU_PINS-1:0]  wake_edge_select_r;
  logic [MWU_PINS-1:0]  wake_pending_flags_r;
  logic [MWU_PINS-1:0]  wake_pending_flags_nxt;
  logic                 global_irq_enable_r;
  logic                 pin_group_irq_enable_r;
  logic                 idle_timer_irq_enable_r;
  logic                 idle_timer_pending_r;
  logic                 idle_timer_pending_nxt;
  logic [MWU_TMR_W-1:0] idle_timer_r;
  logic [5:0]           tc_div_r;
  logic [8:0]           settle_cnt_r;
  logic [8:0]           settle_cnt_nxt;
  logic                 halt_strap_meta_r;
  logic                 halt_allowed_r;
  logic [7:0]           rdata_r;
  logic [7:0]           rdata_nxt;
  logic                 resume_r;
  mwu_pwr_e             state_r;
  mwu_pwr_e             state_nxt;

  logic [MWU_PINS-1:0]  pin_rise;
  logic [MWU_PINS-1:0]  pin_fall;
  logic [MWU_PINS-1:0]  pin_trig;
  logic                 can_fall;
  logic                 wr_en;
  logic                 wr_edge;
  logic                 wr_pnd;
  logic                 wr_ctrl;
  logic                 halt_req;
  logic                 idle_req;
  logic                 halt_blocked;
  logic                 pin_wake;
  logic                 wake_any;
  logic                 clk_running;
  logic                 tc_tick;
  logic                 timer_toggle;

  // Pins and CAN comparator are asynchronous, so both are synchronised
  mwu_sync_edge #(
    .W (MWU_PINS)
  ) u_pin_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (wake_pin_in),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  mwu_sync_edge #(
    .W (1)
  ) u_can_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (can_rx_comp),
    .rise     (),
    .fall     (can_fall)
  );

  // Per-pin trigger selection
  genvar gi;
  generate
    for (gi = 0; gi < MWU_PINS; gi++) begin : g_trig
      assign pin_trig[gi] = wake_edge_select_r[gi] ? pin_fall[gi] : pin_rise[gi];
    end
  endgenerate

  // Write decoding
  assign wr_en   = bus.wr && reg_hit(bus.addr, MWU_OFF_WAKE_EN);
  assign wr_edge = bus.wr && reg_hit(bus.addr, MWU_OFF_WAKE_EDGE);
  assign wr_pnd  = bus.wr && reg_hit(bus.addr, MWU_OFF_WAKE_PND);
  assign wr_ctrl = bus.wr && reg_hit(bus.addr, MWU_OFF_CTRL);

  // Mode requests; halt also needs the mask-option strap
  assign halt_blocked = |(wake_enable_mask_r & wake_pending_flags_r);
  assign halt_req     = wr_ctrl && bus.wdata[MWU_CTRL_HALT_REQ] && halt_allowed_r;
  assign idle_req     = wr_ctrl && bus.wdata[MWU_CTRL_IDLE_REQ];

  // Wake sources: an enabled pin that is pending or triggering now, or CAN
  assign pin_wake = |(wake_enable_mask_r & (wake_pending_flags_r | pin_trig));
  assign wake_any = pin_wake || can_fall;

  // Instruction clock tick; stops with the oscillator in HALT
  assign clk_running  = (state_r != PWR_HALT);
  assign tc_tick      = clk_running && (tc_div_r == 6'(TC_CYCLES - 1));
  assign timer_toggle = tc_tick && (state_r != PWR_SETTLE)
                        && (&idle_timer_r[MWU_TOGGLE_BIT-1:0]);

  // Hardware sets win over a software clear in the same cycle
  assign wake_pending_flags_nxt = (wr_pnd ? bus.wdata : wake_pending_flags_r)
                                  | pin_trig;
  assign idle_timer_pending_nxt = (wr_ctrl ? bus.wdata[MWU_CTRL_IDLE_TIMER_PENDING] : idle_timer_pending_r)
                                  | timer_toggle;

  // Software registers, all zero after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_enable_mask_r      <= MWU_RST_BYTE;
      wake_edge_select_r      <= MWU_RST_BYTE;
      wake_pending_flags_r    <= MWU_RST_BYTE;
      global_irq_enable_r     <= 1'b0;
      pin_group_irq_enable_r  <= 1'b0;
      idle_timer_irq_enable_r <= 1'b0;
      idle_timer_pending_r    <= 1'b0;
    end else begin
      if (wr_en) begin
        wake_enable_mask_r <= bus.wdata;
      end
      if (wr_edge) begin
        wake_edge_select_r <= bus.wdata;
      end
      if (wr_ctrl) begin
        global_irq_enable_r     <= bus.wdata[MWU_CTRL_GIE];
        pin_group_irq_enable_r  <= bus.wdata[MWU_CTRL_PIN_GROUP_IRQ_ENABLE];
        idle_timer_irq_enable_r <= bus.wdata[MWU_CTRL_IDLE_TIMER_IRQ_ENABLE];
      end
      wake_pending_flags_r <= wake_pending_flags_nxt;
      idle_timer_pending_r <= idle_timer_pending_nxt;
    end
  end

  // Strap comes from outside the clock domain, so two flops before use
  always_ff @(posedge clk) begin
    if (reset) begin
      halt_strap_meta_r <= 1'b0;
      halt_allowed_r    <= 1'b0;
    end else begin
      halt_strap_meta_r <= halt_feature_enable;
      halt_allowed_r    <= halt_strap_meta_r;
    end
  end

  // Instruction-cycle divider, held in HALT, and idle timer, paused in HALT and SETTLE
  always_ff @(posedge clk) begin
    if (reset) begin
      tc_div_r     <= 6'h00;
      idle_timer_r <= MWU_RST_TIMER;
    end else begin
      // Held at zero in HALT, so each settle phase starts on a fresh tick
      if (clk_running) begin
        tc_div_r <= tc_tick ? 6'h00 : tc_div_r + 6'h01;
      end else begin
        tc_div_r <= 6'h00;
      end
      if (tc_tick && state_r != PWR_SETTLE) begin
        idle_timer_r <= idle_timer_r + 13'h0001;
      end
    end
  end

  // Power-mode sequencing; HALT takes priority if both bits are written
  always_comb begin
    state_nxt      = state_r;
    settle_cnt_nxt = settle_cnt_r;
    unique case (state_r)
      PWR_RUN: begin
        if (halt_req && !halt_blocked) begin
          state_nxt = PWR_HALT;
        end else if (idle_req && !halt_req) begin
          state_nxt = PWR_IDLE;
        end
      end
      PWR_HALT: begin
        if (wake_any) begin
          state_nxt      = PWR_SETTLE;
          settle_cnt_nxt = MWU_SETTLE_LOAD;
        end
      end
      PWR_SETTLE: begin
        if (settle_cnt_r == 9'h000) begin
          state_nxt = PWR_RUN;
        end else if (tc_tick) begin
          settle_cnt_nxt = settle_cnt_r - 9'h001;
        end
      end
      PWR_IDLE: begin
        if (wake_any || timer_toggle) begin
          state_nxt = PWR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r      <= PWR_RUN;
      settle_cnt_r <= 9'h000;
      resume_r     <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      resume_r     <= (state_r != PWR_RUN) && (state_nxt == PWR_RUN);
    end
  end

  // Interrupts: pins 0..6 only; CAN wake is not a term here
  assign irq_pin_group  = global_irq_enable_r && pin_group_irq_enable_r
                          && |(wake_enable_mask_r[MWU_IRQ_PINS-1:0]
                               & wake_pending_flags_r[MWU_IRQ_PINS-1:0]);
  assign irq_idle_timer = global_irq_enable_r && idle_timer_irq_enable_r
                          && idle_timer_pending_r;

  // Interrupts follow the pending flags directly, so a pin interrupt is up before the resume from HALT and with it from IDLE
  assign resume_pulse      = resume_r;
  assign core_clock_enable = (state_r == PWR_RUN);
  assign osc_enable        = (state_r != PWR_HALT);
  assign power_state       = state_r;

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_nxt = MWU_RST_BYTE;
    if (reg_hit(bus.addr, MWU_OFF_WAKE_EN)) begin
      rdata_nxt = wake_enable_mask_r;
    end else if (reg_hit(bus.addr, MWU_OFF_WAKE_EDGE)) begin
      rdata_nxt = wake_edge_select_r;
    end else if (reg_hit(bus.addr, MWU_OFF_WAKE_PND)) begin
      rdata_nxt = wake_pending_flags_r;
    end else if (reg_hit(bus.addr, MWU_OFF_CTRL)) begin
      rdata_nxt[MWU_CTRL_GIE]   = global_irq_enable_r;
      rdata_nxt[MWU_CTRL_PIN_GROUP_IRQ_ENABLE]  = pin_group_irq_enable_r;
      rdata_nxt[MWU_CTRL_IDLE_TIMER_IRQ_ENABLE]  = idle_timer_irq_enable_r;
      rdata_nxt[MWU_CTRL_IDLE_TIMER_PENDING] = idle_timer_pending_r;
    end else if (reg_hit(bus.addr, MWU_OFF_STATUS)) begin
      rdata_nxt[1:0] = state_r;
      rdata_nxt[2]   = halt_allowed_r;
      rdata_nxt[3]   = halt_blocked;
    end else if (reg_hit(bus.addr, MWU_OFF_TMR_LO)) begin
      rdata_nxt = idle_timer_r[7:0];
    end else if (reg_hit(bus.addr, MWU_OFF_TMR_HI)) begin
      rdata_nxt[4:0] = idle_timer_r[12:8];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= MWU_RST_BYTE;
    end else begin
      rdata_r <= bus.rd ? rdata_nxt : MWU_RST_BYTE;
    end
  end

  assign rdata = rdata_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_in_halt;
    state_r == PWR_HALT;
  endsequence

  sequence s_can_wake;
    can_fall && !pin_wake;
  endsequence

  property p_can_wake_quiet;
    s_in_halt ##0 s_can_wake |=> (state_r == PWR_SETTLE) && !irq_pin_group
                                 && ($stable(wake_pending_flags_r));
  endproperty

  a_halt_blocked: assert property (
    (state_r == PWR_RUN) && halt_req && halt_blocked |=> state_r != PWR_HALT)
    else $error("halt entered while an enabled pin was pending");

  a_pending_sticky: assert property (
    !wr_pnd |=> (wake_pending_flags_r & $past(wake_pending_flags_r))
                == $past(wake_pending_flags_r))
    else $error("pending flag dropped without a software write");

  a_edge_sets_pnd: assert property (
    |pin_trig |=> (wake_pending_flags_r & $past(pin_trig)) == $past(pin_trig))
    else $error("selected edge did not set its pending flag");

  a_can_wake_quiet: assert property (p_can_wake_quiet)
    else $error("CAN wake from halt misbehaved");

  a_group_irq_gate: assert property (
    !global_irq_enable_r || !pin_group_irq_enable_r || !halt_blocked |-> !irq_pin_group)
    else $error("pin group interrupt raised without its enables");

  a_idle_timer_exit: assert property (
    (state_r == PWR_IDLE) && timer_toggle |=> (state_r == PWR_RUN) && resume_pulse)
    else $error("idle timer toggle did not end IDLE");

  a_timer_pnd_set: assert property (
    timer_toggle |=> idle_timer_pending_r [*2])
    else $error("idle timer pending not latched");

  a_timer_irq_gate: assert property (
    !idle_timer_irq_enable_r |-> !irq_idle_timer)
    else $error("idle timer interrupt raised while disabled");

  a_settle_end: assert property (
    (state_r == PWR_SETTLE) && (settle_cnt_r == 9'h000) |=> (state_r == PWR_RUN)
    ##0 core_clock_enable)
    else $error("settle did not release the core clock");

  a_reset_clears: assert property (disable iff (1'b0)
    reset |=> (wake_enable_mask_r == 8'h00) && (wake_pending_flags_r == 8'h00)
              && (wake_edge_select_r == 8'h00) && (state_r == PWR_RUN))
    else $error("wake registers not cleared by reset");

endmodule : mwu_wakeup

// ===== testbench/mwu_pin_model.sv
// Behavioural model of the wake pins and the CAN receive comparator
`timescale 1ns/1ps
module mwu_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_target,
  input  wire logic       can_target,
  input  wire logic       slow,
  output logic      [7:0] wake_pin_in,
  output logic            can_rx_comp
);
  int unsigned lag;

  // Pins move off the clock edge, promptly or after a lag; comparator idles recessive
  initial begin
    wake_pin_in = 8'h00;
    can_rx_comp = 1'b1;
    forever begin
      @(posedge clk);
      lag = slow ? 5 : 0;
      repeat (lag) @(posedge clk);
      #7;
      wake_pin_in = pin_target;
      can_rx_comp = can_target;
    end
  end
endmodule : mwu_pin_model

// ===== testbench/mwu_wakeup_bench.sv
// Self-checking bench for the wake-up block
`timescale 1ns/1ps
module mwu_wakeup_bench;
  import mwu_pkg::*;
  localparam int TC = 2;
  logic       clk;
  logic       reset;
  mwu_bus_s   bus;
  logic [7:0] rdata;
  logic [7:0] pins;
  logic [7:0] pin_target;
  logic       can_rx;
  logic       can_target;
  logic       slow;
  logic       hfe;
  logic       core_en;
  logic       osc_en;
  mwu_pwr_e   pstate;
  logic       irq_pg;
  logic       irq_it;
  logic       resume;
  logic       rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic       e;
  int         num_errors;
  int         compares;
  int         n;

  mwu_pin_model PINS (.clk(clk), .pin_target(pin_target), .can_target(can_target),
    .slow(slow), .wake_pin_in(pins), .can_rx_comp(can_rx));

  mwu_wakeup #(.TC_CYCLES(TC)) DUT (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
    .wake_pin_in(pins), .can_rx_comp(can_rx), .halt_feature_enable(hfe),
    .core_clock_enable(core_en), .osc_enable(osc_en), .power_state(pstate),
    .irq_pin_group(irq_pg), .irq_idle_timer(irq_it), .resume_pulse(resume));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // One-cycle strobes, a gap edge between requests
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
  endtask : rd

  // Bounded wait; the caller judges the state reached
  task automatic wait_state(input mwu_pwr_e s, input int lim);
    int k;
    k = 0;
    while (pstate !== s && k < lim) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_state

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen === 1'b1) check("rdata", 16'(rdata), 16'(exp_q.pop_front()));
    rd_seen <= bus.rd;
  end

  // Watchdog well past the longest idle-timer wait
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    reset = 1'b1;
    bus = '0;
    hfe = 1'b1;
    pin_target = 8'h00;
    can_target = 1'b1;
    slow = 1'b0;
    void'($urandom(32'hE5EE));
    tick(16);
    reset <= 1'b0;
    // Reset values, unmapped place, random read-back
    for (int a = 0; a < 4; a++) rd(4'(a), 8'h00);
    rd(4'hF, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      wr(MWU_OFF_WAKE_EN, v);
      rd(MWU_OFF_WAKE_EN, v);
      v = 8'($urandom);
      wr(MWU_OFF_WAKE_EDGE, v);
      rd(MWU_OFF_WAKE_EDGE, v);
    end
    wr(MWU_OFF_WAKE_EN, 8'h00);
    // Each pin, random edge: the selected edge latches, nothing but a write clears it
    for (int i = 0; i < 8; i++) begin
      e = 1'($urandom);
      slow <= 1'(i);
      wr(MWU_OFF_WAKE_EDGE, 8'(e) << i);
      pin_target[i] <= e;
      tick(12);
      wr(MWU_OFF_WAKE_PND, 8'h00);
      pin_target[i] <= ~e;
      tick(12);
      rd(MWU_OFF_WAKE_PND, 8'h01 << i);
      pin_target[i] <= 1'b0;
      tick(12);
      rd(MWU_OFF_WAKE_PND, 8'h01 << i);
      wr(MWU_OFF_WAKE_PND, 8'h00);
    end
    slow <= 1'b0;
    // Pin 7 never interrupts; then every enable combination
    wr(MWU_OFF_WAKE_EN, 8'h81);
    wr(MWU_OFF_WAKE_PND, 8'h80);
    wr(MWU_OFF_CTRL, 8'h03);
    tick(2);
    check("irq_pg", 16'(irq_pg), 16'h0000);
    wr(MWU_OFF_WAKE_PND, 8'h01);
    for (int c = 0; c < 16; c++) begin
      wr(MWU_OFF_CTRL, 8'(c));
      tick(1);
      check("irq_pg", 16'(irq_pg), 16'(c[0] & c[1]));
      check("irq_it", 16'(irq_it), 16'(c[0] & c[2] & c[3]));
      rd(MWU_OFF_CTRL, 8'(c));
    end
    // Halt refused while enabled and pending, or with the feature masked off
    wr(MWU_OFF_CTRL, 8'h80);
    tick(3);
    check("state", 16'(pstate), 16'(PWR_RUN));
    rd(MWU_OFF_STATUS, 8'h0C);
    wr(MWU_OFF_WAKE_PND, 8'h00);
    hfe <= 1'b0;
    tick(2);
    wr(MWU_OFF_CTRL, 8'h80);
    tick(3);
    check("state", 16'(pstate), 16'(PWR_RUN));
    hfe <= 1'b1;
    tick(2);
    wr(MWU_OFF_CTRL, 8'h83);
    tick(3);
    check("state", 16'(pstate), 16'(PWR_HALT));
    check("osc", 16'(osc_en), 16'h0000);
    // Pin wake from halt, settle count, service on resume
    pin_target[0] <= 1'b1;
    wait_state(PWR_SETTLE, 30);
    check("state", 16'(pstate), 16'(PWR_SETTLE));
    check("core_en", 16'(core_en), 16'h0000);
    n = 0;
    while (pstate === PWR_SETTLE && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("settle", 16'(n), 16'(256 * TC + 1));
    check("resume", 16'(resume), 16'h0001);
    check("irq_pg", 16'(irq_pg), 16'h0001);
    pin_target[0] <= 1'b0;
    // Comparator fall always wakes, raises nothing
    wr(MWU_OFF_WAKE_EN, 8'h00);
    wr(MWU_OFF_WAKE_PND, 8'h00);
    wr(MWU_OFF_CTRL, 8'h83);
    tick(3);
    can_target <= 1'b0;
    wait_state(PWR_SETTLE, 30);
    check("state", 16'(pstate), 16'(PWR_SETTLE));
    wait_state(PWR_RUN, 600);
    check("irq_pg", 16'(irq_pg), 16'h0000);
    check("irq_it", 16'(irq_it), 16'h0000);
    rd(MWU_OFF_WAKE_PND, 8'h00);
    can_target <= 1'b1;
    // Edge change in four steps, then idle: disabled pin stays asleep
    pin_target[2] <= 1'b1;
    tick(12);
    wr(MWU_OFF_WAKE_EN, 8'h00);
    wr(MWU_OFF_WAKE_EDGE, 8'h04);
    wr(MWU_OFF_WAKE_PND, 8'h00);
    wr(MWU_OFF_WAKE_EN, 8'h04);
    wr(MWU_OFF_CTRL, 8'h40);
    tick(2);
    check("state", 16'(pstate), 16'(PWR_IDLE));
    pin_target[1] <= 1'b1;
    tick(12);
    check("state", 16'(pstate), 16'(PWR_IDLE));
    pin_target[2] <= 1'b0;
    wait_state(PWR_RUN, 30);
    check("state", 16'(pstate), 16'(PWR_RUN));
    rd(MWU_OFF_WAKE_PND, 8'h06);
    // Idle ends on the timer toggle, pending latched, request raised
    wr(MWU_OFF_WAKE_PND, 8'h00);
    wr(MWU_OFF_CTRL, 8'h45);
    tick(2);
    check("state", 16'(pstate), 16'(PWR_IDLE));
    wait_state(PWR_RUN, 4096 * TC + 100);
    check("state", 16'(pstate), 16'(PWR_RUN));
    tick(1);
    check("irq_it", 16'(irq_it), 16'h0001);
    rd(MWU_OFF_CTRL, 8'h0D);
    // Reset in mid-idle returns to run with cleared registers
    wr(MWU_OFF_CTRL, 8'h40);
    tick(2);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    check("state", 16'(pstate), 16'(PWR_RUN));
    rd(MWU_OFF_WAKE_EN, 8'h00);
    tick(4);
    stop_test();
  end
endmodule : mwu_wakeup_bench
